// ==== verilog/tlic_consts.vh ====
// constants for the two-level interrupt controller
`ifndef TLIC_CONSTS_VH
`define TLIC_CONSTS_VH
`define TLIC_ADDR_CTRL 12'h000
`define TLIC_ADDR_FLAG 12'h004
`define TLIC_ADDR_EN 12'h008
`define TLIC_ADDR_PRIO 12'h00c
`define TLIC_ADDR_PERIPH 12'h010
`define TLIC_ADDR_STATUS 12'h014
`define TLIC_ADDR_EDGE 12'h018
`define TLIC_ADDR_VECTOR 12'h01c
`define TLIC_CTRL_HIGH_LEVEL_GLOBAL_ENABLE_BIT 7
`define TLIC_CTRL_LOW_LEVEL_GLOBAL_ENABLE_BIT 6
`define TLIC_RST_CTRL_PLE_BIT 7
`define TLIC_VEC_HIGH 21'h000008
`define TLIC_VEC_LOW 21'h000018
`define TLIC_LAT_MIN 3
`define TLIC_LAT_MAX 4
`define TLIC_EDGE_RST 3'h7
`define TLIC_PRIO_RST 32'hffffffff
`endif

// ==== verilog/tlic_edge_detect.v ====
// edge detector for external interrupt pins
module tlic_edge_detect #(
  parameter N = 3
) (
  input wire core_clk,
  input wire nrst,
  input wire [N-1:0] pin_in,
  input wire [N-1:0] rising_sel,
  output wire [N-1:0] edge_pulse
);
  reg [N-1:0] prev_q;

  always @(posedge core_clk) begin
    if (!nrst) begin
      prev_q <= {N{1'b0}};
    end else begin
      prev_q <= pin_in;
    end
  end

  // 1 selects rising edge, 0 selects falling edge
  assign edge_pulse = (rising_sel & pin_in & ~prev_q) |
                      (~rising_sel & ~pin_in & prev_q);
endmodule

// ==== verilog/tlic_core.v ====
// two-level prioritised interrupt controller with apb registers
// Function
// - priority mode vectors high 000008h, low 000018h
// - high request pre-empts low service routine
// - each source has flag, enable, priority
// - priority mode only when enable bit set
// - high global enable gates high sources
// - low global enable gates low sources
// - eligible request vectors at once by priority
// - default compatibility mode, priority bits ignored
// - compat: bit6 peripherals, bit7 all sources
// - compatibility mode always vectors to 000008h
// - accepting clears the applicable global enable
// - high service holds off low requests
// - accept pushes return address, loads vector
// - return instruction re-sets cleared global enable; a return is ignored here in ST_WAIT or in the cycle a request enters ST_WAIT
// - external events vector within three-four cycles
// - flags set regardless of any enable
// - edge select: 1 rising, 0 falling
`include "tlic_consts.vh"
module tlic_core #(
  parameter NSRC = 16,
  parameter NEXT = 3,
  parameter PCW = 21
) (
  input wire core_clk,
  input wire nrst,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // event sources
  input wire [NSRC-1:0] src_event,
  input wire [NEXT-1:0] external_irq_pins,
  input wire [3:0] change_notify_port,
  // core sequencer side
  input wire instr_boundary,
  input wire return_from_isr_instr,
  input wire [PCW-1:0] return_addr,
  output reg irq_take,
  output reg [PCW-1:0] vector_addr,
  output reg stack_push,
  output reg [PCW-1:0] stack_data,
  output wire in_high_isr,
  output wire in_low_isr
);
  // source map: [NEXT-1:0] external pins, [NEXT] port change,
  // [NSRC-1:NEXT+1] peripherals, OR-ed with src_event
  localparam ST_IDLE = 2'd0;
  localparam ST_WAIT = 2'd1;

  reg [31:0] flag_q;
  reg [31:0] en_q;
  reg [31:0] prio_q;
  reg [31:0] periph_q;
  reg [NEXT-1:0] edge_sel_q;
  reg priority_levels_enable_q;
  reg high_level_global_enable_q;
  reg low_level_global_enable_q;
  reg high_act_q;
  reg low_act_q;
  reg high_was_q;
  reg [1:0] st_q;
  reg [2:0] lat_q;
  reg req_hi_q;
  reg [3:0] port_prev_q;
  wire [NEXT-1:0] ext_edge;
  wire port_change;
  wire [NSRC-1:0] raw_evt;
  wire [NSRC-1:0] pend;
  wire [NSRC-1:0] is_hi;
  wire [NSRC-1:0] is_per;
  wire any_hi;
  wire any_lo;
  wire any_compat;
  wire wr_en;
  wire rd_en;

  // ------------------------------------------------------------
  // event capture
  // ------------------------------------------------------------
  tlic_edge_detect #(
    .N(NEXT)
  ) u_edge (
    .core_clk(core_clk),
    .nrst(nrst),
    .pin_in(external_irq_pins),
    .rising_sel(edge_sel_q),
    .edge_pulse(ext_edge)
  );

  always @(posedge core_clk) begin
    if (!nrst) begin
      port_prev_q <= 4'h0;
    end else begin
      port_prev_q <= change_notify_port;
    end
  end

  assign port_change = |(port_prev_q ^ change_notify_port);
  assign raw_evt = src_event | {{(NSRC-NEXT-1){1'b0}}, port_change, ext_edge};

  // ------------------------------------------------------------
  // dispatch qualification
  // ------------------------------------------------------------
  assign pend = flag_q[NSRC-1:0] & en_q[NSRC-1:0];
  // peripherals are the sources marked in the peripheral map
  assign is_per = periph_q[NSRC-1:0];
  assign is_hi = prio_q[NSRC-1:0];
  assign any_hi = |(pend & is_hi) & high_level_global_enable_q;
  // low waits while a high routine runs
  assign any_lo = |(pend & ~is_hi) & low_level_global_enable_q & ~high_act_q;
  // compat: bit7 gates all, bit6 also gates peripherals; priority bits unused
  assign any_compat = high_level_global_enable_q &
                      |(pend & (~is_per | {NSRC{low_level_global_enable_q}}));

  assign in_high_isr = high_act_q;
  assign in_low_isr = low_act_q;

  // ------------------------------------------------------------
  // apb slave
  // ------------------------------------------------------------
  assign pready = 1'b1;
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & ~pwrite;
  assign pslverr = psel & penable & ~addr_ok(paddr);

  function addr_ok;
    input [11:0] a;
    begin
      addr_ok = (a[1:0] == 2'b00) && (a <= `TLIC_ADDR_VECTOR);
    end
  endfunction

  function [31:0] pad_src;
    input [NSRC-1:0] v;
    begin
      pad_src = {{(32-NSRC){1'b0}}, v};
    end
  endfunction

  always @(posedge core_clk) begin
    if (!nrst) begin
      prdata <= 32'h00000000;
    end else if (rd_en && !penable) begin
      if (paddr == `TLIC_ADDR_CTRL) begin
        prdata <= {24'h000000, high_level_global_enable_q, low_level_global_enable_q, 6'h00};
      end else if (paddr == `TLIC_ADDR_FLAG) begin
        prdata <= flag_q;
      end else if (paddr == `TLIC_ADDR_EN) begin
        prdata <= en_q;
      end else if (paddr == `TLIC_ADDR_PRIO) begin
        prdata <= prio_q;
      end else if (paddr == `TLIC_ADDR_PERIPH) begin
        prdata <= periph_q;
      end else if (paddr == `TLIC_ADDR_STATUS) begin
        prdata <= {24'h000000, priority_levels_enable_q, 5'h00, high_act_q, low_act_q};
      end else if (paddr == `TLIC_ADDR_EDGE) begin
        prdata <= {{(32-NEXT){1'b0}}, edge_sel_q};
      end else if (paddr == `TLIC_ADDR_VECTOR) begin
        prdata <= {{(32-PCW){1'b0}}, vector_addr};
      end else begin
        prdata <= 32'h00000000;
      end
    end
  end

  // ------------------------------------------------------------
  // flags, enables, priorities
  // ------------------------------------------------------------
  // event wins over a same-cycle software clear
  always @(posedge core_clk) begin
    if (!nrst) begin
      flag_q <= 32'h00000000;
      en_q <= 32'h00000000;
      prio_q <= `TLIC_PRIO_RST;
      periph_q <= 32'h00000000;
      edge_sel_q <= `TLIC_EDGE_RST;
      priority_levels_enable_q <= 1'b0;
    end else begin
      if (wr_en && paddr == `TLIC_ADDR_FLAG) begin
        flag_q <= pad_src(pwdata[NSRC-1:0] | raw_evt);
      end else begin
        flag_q <= flag_q | pad_src(raw_evt);
      end
      if (wr_en && paddr == `TLIC_ADDR_EN) begin
        en_q <= pad_src(pwdata[NSRC-1:0]);
      end
      if (wr_en && paddr == `TLIC_ADDR_PRIO) begin
        prio_q <= pad_src(pwdata[NSRC-1:0]);
      end
      if (wr_en && paddr == `TLIC_ADDR_PERIPH) begin
        periph_q <= pad_src(pwdata[NSRC-1:0]);
      end
      if (wr_en && paddr == `TLIC_ADDR_EDGE) begin
        edge_sel_q <= pwdata[NEXT-1:0];
      end
      if (wr_en && paddr == `TLIC_ADDR_STATUS) begin
        priority_levels_enable_q <= pwdata[`TLIC_RST_CTRL_PLE_BIT];
      end
    end
  end

  // ------------------------------------------------------------
  // dispatch sequencer
  // ------------------------------------------------------------
  // accept waits for an instruction boundary, at least LAT_MIN-1 cycles
  // after the request is seen; the LAT_MAX cap forces the take
  always @(posedge core_clk) begin
    if (!nrst) begin
      st_q <= ST_IDLE;
      lat_q <= 3'd0;
      req_hi_q <= 1'b0;
      high_level_global_enable_q <= 1'b0;
      low_level_global_enable_q <= 1'b0;
      high_act_q <= 1'b0;
      low_act_q <= 1'b0;
      high_was_q <= 1'b0;
      irq_take <= 1'b0;
      stack_push <= 1'b0;
      vector_addr <= `TLIC_VEC_HIGH;
      stack_data <= {PCW{1'b0}};
    end else begin
      irq_take <= 1'b0;
      stack_push <= 1'b0;
      if (wr_en && paddr == `TLIC_ADDR_CTRL) begin
        high_level_global_enable_q <= pwdata[`TLIC_CTRL_HIGH_LEVEL_GLOBAL_ENABLE_BIT];
        low_level_global_enable_q <= pwdata[`TLIC_CTRL_LOW_LEVEL_GLOBAL_ENABLE_BIT];
      end
      case (st_q)
        ST_IDLE: begin
          if (priority_levels_enable_q ? (any_hi | any_lo) : any_compat) begin
            st_q <= ST_WAIT;
            lat_q <= 3'd1;
            req_hi_q <= priority_levels_enable_q ? any_hi : 1'b1;
          end else if (return_from_isr_instr) begin
            // re-enable the enable cleared on entry
            if (!priority_levels_enable_q || high_act_q) begin
              high_level_global_enable_q <= 1'b1;
              high_act_q <= 1'b0;
              low_act_q <= priority_levels_enable_q & low_act_q & high_was_q;
            end else begin
              low_level_global_enable_q <= 1'b1;
              low_act_q <= 1'b0;
            end
          end
        end
        ST_WAIT: begin
          lat_q <= lat_q + 3'd1;
          if (priority_levels_enable_q && any_hi) begin
            req_hi_q <= 1'b1;
          end
          if ((instr_boundary && lat_q >= (`TLIC_LAT_MIN - 1)) ||
              lat_q >= (`TLIC_LAT_MAX - 1)) begin
            st_q <= ST_IDLE;
            irq_take <= 1'b1;
            stack_push <= 1'b1;
            stack_data <= return_addr;
            if (req_hi_q || (priority_levels_enable_q && any_hi)) begin
              vector_addr <= `TLIC_VEC_HIGH;
              high_level_global_enable_q <= 1'b0;
              high_was_q <= low_act_q;
              high_act_q <= 1'b1;
            end else begin
              vector_addr <= `TLIC_VEC_LOW;
              low_level_global_enable_q <= 1'b0;
              low_act_q <= 1'b1;
            end
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end
endmodule

// ==== dv/tlic_cpu_model.sv ====
// core sequencer model facing the dispatch side of the controller
module tlic_cpu_model (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic slow,
  input wire logic ret_req,
  output logic instr_boundary,
  output logic return_from_isr_instr,
  output logic [20:0] return_addr
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [20:0] pc_q;
  always @(posedge core_clk) begin
    if (!nrst) begin
      pc_q <= 21'h000100;
      return_from_isr_instr <= 1'b0;
    end else begin
      pc_q <= pc_q + 21'h000001;
      // return only on command, one cycle after ret_req, whatever the flags hold
      return_from_isr_instr <= ret_req;
    end
  end
  // slow: two-cycle instructions, boundary every other cycle
  assign instr_boundary = !slow || pc_q[0];
  assign return_addr = pc_q;
endmodule

// ==== dv/tlic_assertions.sv ====
// checker for dispatch and return at the controller ports
`include "tlic_consts.vh"
module tlic_assertions (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic return_from_isr_instr,
  input wire logic [20:0] return_addr,
  input wire logic irq_take,
  input wire logic [20:0] vector_addr,
  input wire logic stack_push,
  input wire logic [20:0] stack_data,
  input wire logic in_high_isr,
  input wire logic in_low_isr
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  sequence s_hi;
    irq_take && vector_addr == `TLIC_VEC_HIGH;
  endsequence
  sequence s_lo;
    irq_take && vector_addr == `TLIC_VEC_LOW;
  endsequence
  property p_push;
    irq_take |-> stack_push;
  endproperty
  a_push: assert property (p_push) else $error("take without push");
  property p_vec;
    irq_take |-> vector_addr == `TLIC_VEC_HIGH || vector_addr == `TLIC_VEC_LOW;
  endproperty
  a_vec: assert property (p_vec) else $error("bad vector");
  property p_pulse;
    irq_take |=> !irq_take && !stack_push;
  endproperty
  a_pulse: assert property (p_pulse) else $error("take too long");
  property p_data;
    irq_take |-> stack_data == $past(return_addr);
  endproperty
  a_data: assert property (p_data) else $error("wrong pushed address");
  property p_hold;
    s_lo |-> !$past(in_high_isr);
  endproperty
  a_hold: assert property (p_hold) else $error("low taken in high");
  property p_hin;
    s_hi |-> ##[0:1] in_high_isr;
  endproperty
  a_hin: assert property (p_hin) else $error("high not entered");
  property p_lin;
    s_lo |-> ##[0:1] in_low_isr;
  endproperty
  a_lin: assert property (p_lin) else $error("low not entered");
  property p_ret;
    $fell(in_high_isr) |-> $past(return_from_isr_instr);
  endproperty
  a_ret: assert property (p_ret) else $error("left without return");
endmodule
bind tlic_core tlic_assertions tlic_assertions_i (.core_clk, .nrst, .return_from_isr_instr,
  .return_addr, .irq_take, .vector_addr, .stack_push, .stack_data, .in_high_isr, .in_low_isr);

// ==== dv/tb.sv ====
// self-checking bench for the two-level interrupt controller
`include "tlic_consts.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, slow = 0, ret_req = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, perr, instr_boundary, return_from_isr_instr, irq_take, stack_push;
  logic in_high_isr, in_low_isr;
  logic [15:0] src_event = 16'h0;
  logic [2:0] external_irq_pins = 3'h0;
  logic [3:0] change_notify_port = 4'h0;
  logic [20:0] return_addr, vector_addr, stack_data;
  int n_fail = 0, check_count = 0, cyc = 0, n_take = 0, k;
  always #50 core_clk = ~core_clk;
  tlic_core tlic_core_i (.core_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .src_event, .external_irq_pins, .change_notify_port, .instr_boundary,
    .return_from_isr_instr, .return_addr, .irq_take, .vector_addr, .stack_push, .stack_data,
    .in_high_isr, .in_low_isr);
  tlic_cpu_model tlic_cpu_model_i (.core_clk, .nrst, .slow, .ret_req, .instr_boundary,
    .return_from_isr_instr, .return_addr);
  task close_out;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (irq_take === 1'b1) n_take <= n_take + 1;
    if (cyc == 8000) begin
      n_fail++;
      close_out;
    end
  end
  task chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      n_fail++;
      $display("unexpected at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  // single plain word reads or writes only, never a block move into control space
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task ev(input logic [15:0] m);
    @(posedge core_clk);
    src_event <= m;
    @(posedge core_clk);
    src_event <= 16'h0;
  endtask
  task take(input logic [20:0] e);
    for (int i = 0; i < 12 && irq_take !== 1'b1; i++) @(posedge core_clk);
    chk(vector_addr, e);
    @(posedge core_clk);
  endtask
  task none;
    int t;
    t = n_take;
    repeat (10) @(posedge core_clk);
    chk(n_take - t, 0);
  endtask
  task ret;
    @(posedge core_clk);
    ret_req <= 1'b1;
    @(posedge core_clk);
    ret_req <= 1'b0;
  endtask
  task t_reset;
    rdc(`TLIC_ADDR_PRIO, `TLIC_PRIO_RST);
    rdc(`TLIC_ADDR_STATUS, 32'h0);
    rdc(`TLIC_ADDR_EDGE, `TLIC_EDGE_RST);
    apb(1'b1, 12'h020, 32'h1);
    chk(perr, 1'b1);
    rdc(12'h020, 32'h0);
  endtask
  task t_poll;
    apb(1'b1, `TLIC_ADDR_EDGE, 32'h5);
    @(posedge core_clk);
    external_irq_pins <= 3'h3;
    change_notify_port <= 4'h4;
    src_event <= 16'h0020;
    @(posedge core_clk);
    src_event <= 16'h0;
    rdc(`TLIC_ADDR_FLAG, 32'h29);
    external_irq_pins <= 3'h0;
    rdc(`TLIC_ADDR_FLAG, 32'h2b);
    chk(n_take, 0);
    apb(1'b1, `TLIC_ADDR_FLAG, 32'h0);
    apb(1'b1, `TLIC_ADDR_EDGE, 32'h7);
  endtask
  task t_compat;
    apb(1'b1, `TLIC_ADDR_EN, 32'h10);
    apb(1'b1, `TLIC_ADDR_PRIO, 32'h0);
    apb(1'b1, `TLIC_ADDR_PERIPH, 32'h10);
    apb(1'b1, `TLIC_ADDR_CTRL, 32'h80);
    ev(16'h10);
    none;
    apb(1'b1, `TLIC_ADDR_CTRL, 32'hc0);
    take(`TLIC_VEC_HIGH);
    rdc(`TLIC_ADDR_CTRL, 32'h40);
    apb(1'b1, `TLIC_ADDR_FLAG, 32'h0);
    ret;
    rdc(`TLIC_ADDR_CTRL, 32'hc0);
    apb(1'b1, `TLIC_ADDR_PERIPH, 32'h0);
    apb(1'b1, `TLIC_ADDR_CTRL, 32'h40);
    ev(16'h10);
    none;
    apb(1'b1, `TLIC_ADDR_FLAG, 32'h0);
  endtask
  task t_prio;
    slow <= 1'b1;
    apb(1'b1, `TLIC_ADDR_STATUS, 32'h80);
    apb(1'b1, `TLIC_ADDR_PRIO, 32'h2);
    apb(1'b1, `TLIC_ADDR_EN, 32'h6);
    ev(16'h2);
    none;
    apb(1'b1, `TLIC_ADDR_FLAG, 32'h0);
    apb(1'b1, `TLIC_ADDR_CTRL, 32'h80);
    ev(16'h4);
    none;
    apb(1'b1, `TLIC_ADDR_CTRL, 32'h0);
    ev(16'h2);
    apb(1'b1, `TLIC_ADDR_CTRL, 32'hc0);
    take(`TLIC_VEC_HIGH);
    rdc(`TLIC_ADDR_CTRL, 32'h40);
    none;
    apb(1'b1, `TLIC_ADDR_FLAG, 32'h4);
    ret;
    take(`TLIC_VEC_LOW);
    rdc(`TLIC_ADDR_VECTOR, 32'h18);
    rdc(`TLIC_ADDR_CTRL, 32'h80);
    ev(16'h2);
    take(`TLIC_VEC_HIGH);
    chk(in_high_isr & in_low_isr, 1'b1);
    apb(1'b1, `TLIC_ADDR_FLAG, 32'h0);
    ret;
    repeat (3) @(posedge core_clk);
    chk({in_high_isr, in_low_isr}, 2'b01);
    ret;
    rdc(`TLIC_ADDR_CTRL, 32'hc0);
    apb(1'b1, `TLIC_ADDR_STATUS, 32'h0);
  endtask
  task t_ext;
    apb(1'b1, `TLIC_ADDR_EN, 32'h1);
    apb(1'b1, `TLIC_ADDR_CTRL, 32'h80);
    for (int s = 0; s < 2; s++) begin
      slow <= s[0];
      @(posedge core_clk);
      external_irq_pins <= 3'h1;
      k = 0;
      // pin seen one edge after it is driven, the take pulse one edge after launch
      while (irq_take !== 1'b1 && k < 12) begin
        @(posedge core_clk);
        k++;
      end
      chk(k >= `TLIC_LAT_MIN + 2 && k <= `TLIC_LAT_MAX + 2, 1'b1);
      apb(1'b1, `TLIC_ADDR_FLAG, 32'h0);
      ret;
      external_irq_pins <= 3'h0;
    end
  endtask
  initial begin
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    t_reset;
    t_poll;
    t_compat;
    t_prio;
    t_ext;
    close_out;
  end
endmodule
